/* File: shared/act_regs.svh */
// Reset values, timebase codes and timing counts for the array counter timebase.
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH

// ----------------------------------------------------------------------------
// Reset values and counter maximum
// ----------------------------------------------------------------------------
`define ACT_COUNT_RST   16'h0000
`define ACT_BYTE_RST    8'h00
`define ACT_COUNT_MAX   16'hFFFF

// ----------------------------------------------------------------------------
// Timebase select codes
// ----------------------------------------------------------------------------
`define ACT_TB_SYS_DIV12  3'h0
`define ACT_TB_SYS_DIV4   3'h1
`define ACT_TB_TMR0_OVF   3'h2
`define ACT_TB_EXT_EVENT  3'h3
`define ACT_TB_SYS        3'h4
`define ACT_TB_OSC_DIV8   3'h5

// ----------------------------------------------------------------------------
// Timing counts, in system clocks or source edges
// ----------------------------------------------------------------------------
`define ACT_DIV_SYS12   12
`define ACT_DIV_SYS4    4
`define ACT_DIV_OSC8    8
`define ACT_EVENT_GAP   4
`define ACT_GAP_LAST    2'h3
`define ACT_GAP_ZERO    2'h0

`endif

/* File: shared/act_pkg.sv */
// Types shared by the array counter timebase modules.
package act_pkg;

  typedef logic [7:0]  act_byte_t;
  typedef logic [15:0] act_word_t;

  typedef enum logic [2:0] {
    ACT_TB_SYS_DIV12 = 3'b000,
    ACT_TB_SYS_DIV4  = 3'b001,
    ACT_TB_TMR0_OVF  = 3'b010,
    ACT_TB_EXT_EVENT = 3'b011,
    ACT_TB_SYS       = 3'b100,
    ACT_TB_OSC_DIV8  = 3'b101
  } act_tb_t;

endpackage

/* File: rtl/act_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge detection.
`timescale 1ns/1ns
module act_edge_sync
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output wire logic rise,
  output wire logic fall
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= din;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = prev_r & ~sync2_r;

endmodule // act_edge_sync

/* File: rtl/act_divider.sv */
// Step divider that pulses once for every DIV input steps.
`timescale 1ns/1ns
module act_divider
#(
  parameter int unsigned DIV = 12,
  parameter int unsigned W   = 4
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic step,
  output logic      tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire          last = (cnt_r == W'(DIV - 1));

  assign cnt_nxt = last ? '0 : cnt_r + W'(1);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= step & last;
      if (step)
      begin
        cnt_r <= cnt_nxt;
      end
    end
  end

endmodule // act_divider

/* File: rtl/act_top.sv */
// Array counter timebase: 16-bit counter, timebase select, snapshot and overflow.
`timescale 1ns/1ns
`include "act_regs.svh"
// ----------------------------------------------------------------------------
// Summary of operation
// - One 16-bit up-counter, read by software as high and low bytes.
// - Reading the low byte copies the high byte into a snapshot for later.
// - Byte reads never pause or change counting.
// - Timebase select picks sysclk/12, /4, timer0 overflow, event, sysclk, osc/8.
// - Event mode counts at most one falling edge per four system clocks.
// - Oscillator/8 source is synchronised; it must not outrun the system clock.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow raises an interrupt request only while its enable is one.
// - Flag stays set on vectoring; software clears it.
// - Request needs both global and array interrupt enables.
// - With idle halt zero, counting continues through CPU idle.
// - Overflow during a control register read-modify-write does not set the flag.
// - Counter value is shared with five capture/compare modules.
// ----------------------------------------------------------------------------
module act_top
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [2:0]       timebase_select,
  input  wire logic             idle_halt_control,
  input  wire logic             cpu_idle,
  input  wire logic             timer0_overflow,
  input  wire logic             external_event_input,
  input  wire logic             ext_osc,
  input  wire logic             rd_low,
  input  wire logic             rd_high,
  input  wire logic             flag_wr_en,
  input  wire logic             flag_wr_data,
  input  wire logic             rmw_ctrl_active,
  input  wire logic             overflow_interrupt_enable,
  input  wire logic             global_interrupt_enable,
  input  wire logic             array_interrupt_enable,
  output act_pkg::act_byte_t    rd_data,
  output act_pkg::act_word_t    counter_array,
  output logic                  counter_overflow_flag,
  output logic                  irq
);

  import act_pkg::*;

  // --------------------------------------------------------------------------
  // Timebase sources
  // --------------------------------------------------------------------------
  logic      tick_div12;
  logic      tick_div4;
  logic      tick_osc8;
  logic      osc_rise;
  logic      evt_fall;
  logic [1:0] gap_r;
  logic [1:0] gap_nxt;
  logic      evt_tick_r;

  act_divider #(.DIV(`ACT_DIV_SYS12), .W(4)) u_div12
  (
    .clk   (clk),
    .rst_b (rst_b),
    .step  (1'b1),
    .tick  (tick_div12)
  );

  act_divider #(.DIV(`ACT_DIV_SYS4), .W(2)) u_div4
  (
    .clk   (clk),
    .rst_b (rst_b),
    .step  (1'b1),
    .tick  (tick_div4)
  );

  // The oscillator is retimed before its edges are divided down.
  act_edge_sync u_osc_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (ext_osc),
    .rise  (osc_rise),
    .fall  ()
  );

  act_divider #(.DIV(`ACT_DIV_OSC8), .W(3)) u_div8
  (
    .clk   (clk),
    .rst_b (rst_b),
    .step  (osc_rise),
    .tick  (tick_osc8)
  );

  act_edge_sync u_evt_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (external_event_input),
    .rise  (),
    .fall  (evt_fall)
  );

  // A holdoff keeps accepted events at least four clocks apart; with the
  // two-clock level minimum on the input, no legal edge is lost to it.
  wire evt_accept = evt_fall & (gap_r == `ACT_GAP_ZERO);
  assign gap_nxt = evt_accept ? `ACT_GAP_LAST :
                   (gap_r != `ACT_GAP_ZERO) ? gap_r - 2'h1 : gap_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_r      <= `ACT_GAP_ZERO;
      evt_tick_r <= 1'b0;
    end
    else
    begin
      gap_r      <= gap_nxt;
      evt_tick_r <= evt_accept;
    end
  end

  // --------------------------------------------------------------------------
  // Timebase select and run control
  // --------------------------------------------------------------------------
  logic tb_tick;

  always_comb
  begin
    unique case (timebase_select)
      ACT_TB_SYS_DIV12: tb_tick = tick_div12;
      ACT_TB_SYS_DIV4:  tb_tick = tick_div4;
      ACT_TB_TMR0_OVF:  tb_tick = timer0_overflow;
      ACT_TB_EXT_EVENT: tb_tick = evt_tick_r;
      ACT_TB_SYS:       tb_tick = 1'b1;
      ACT_TB_OSC_DIV8:  tb_tick = tick_osc8;
      default:          tb_tick = 1'b0;
    endcase
  end

  wire run      = ~(idle_halt_control & cpu_idle);
  wire step_cnt = tb_tick & run;

  // --------------------------------------------------------------------------
  // Counter, snapshot and read data
  // --------------------------------------------------------------------------
  act_word_t count_r;
  act_word_t count_nxt;
  act_byte_t snap_r;
  act_byte_t snap_nxt;
  act_byte_t rd_nxt;

  // Reads only touch the snapshot and read data, never the count.
  assign count_nxt = step_cnt ? count_r + 16'h0001 : count_r;
  assign snap_nxt  = rd_low ? count_r[15:8] : snap_r;
  assign rd_nxt    = rd_low  ? count_r[7:0] :
                     rd_high ? snap_r : rd_data;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r       <= `ACT_COUNT_RST;
      counter_array <= `ACT_COUNT_RST;
      snap_r        <= `ACT_BYTE_RST;
      rd_data       <= `ACT_BYTE_RST;
    end
    else
    begin
      count_r       <= count_nxt;
      counter_array <= count_nxt;
      snap_r        <= snap_nxt;
      rd_data       <= rd_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Overflow flag and interrupt request
  // --------------------------------------------------------------------------
  wire wrap     = step_cnt & (count_r == `ACT_COUNT_MAX);
  wire ovf_set  = wrap & ~rmw_ctrl_active;
  logic flag_nxt;
  logic irq_nxt;

  // Hardware set beats a software clear in the same cycle. Nothing clears
  // the flag on vectoring, so software must do it.
  assign flag_nxt = ovf_set ? 1'b1 :
                    flag_wr_en ? flag_wr_data : counter_overflow_flag;
  assign irq_nxt  = counter_overflow_flag & overflow_interrupt_enable
                    & global_interrupt_enable & array_interrupt_enable;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      counter_overflow_flag <= 1'b0;
      irq                   <= 1'b0;
    end
    else
    begin
      counter_overflow_flag <= flag_nxt;
      irq                   <= irq_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_count_step;
    step_cnt |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Counter did not step by one on a tick.");

  property p_snapshot;
    rd_low ##1 (!rd_low [*2]) ##0 rd_high |=> rd_data == $past(snap_r, 1)
      && snap_r == $past(count_r[15:8], 3);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("High byte read did not return the snapshot.");

  property p_low_read;
    rd_low |=> rd_data == $past(count_r[7:0]) && snap_r == $past(count_r[15:8]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("Low byte read returned wrong data or snapshot.");

  property p_read_no_effect;
    (rd_low || rd_high) && !step_cnt |=> $stable(count_r);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("Counter moved on a read without a tick.");

  property p_sysclk_mode;
    (timebase_select == `ACT_TB_SYS && run) [*2] |=> count_r == $past(count_r, 2) + 16'h0002;
  endproperty
  a_sysclk_mode: assert property (p_sysclk_mode)
    else $error("System clock mode did not count every clock.");

  property p_div4_spacing;
    tick_div4 |=> !tick_div4 [*3] ##1 tick_div4;
  endproperty
  a_div4_spacing: assert property (p_div4_spacing)
    else $error("Divide by four tick spacing wrong.");

  property p_event_spacing;
    evt_tick_r |=> !evt_tick_r [*3];
  endproperty
  a_event_spacing: assert property (p_event_spacing)
    else $error("Event ticks closer than four clocks.");

  property p_ovf_set;
    wrap && !rmw_ctrl_active |=> counter_overflow_flag && count_r == `ACT_COUNT_RST;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("Wrap did not set the overflow flag.");

  property p_rmw_lost;
    wrap && rmw_ctrl_active && !counter_overflow_flag && !flag_wr_en
      |=> !counter_overflow_flag;
  endproperty
  a_rmw_lost: assert property (p_rmw_lost)
    else $error("Overflow during read-modify-write set the flag.");

  property p_irq_gate;
    !(overflow_interrupt_enable && global_interrupt_enable && array_interrupt_enable)
      |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt raised without all enables.");

  property p_irq_raise;
    counter_overflow_flag && overflow_interrupt_enable && global_interrupt_enable
      && array_interrupt_enable |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Interrupt missing with flag and enables set.");

  property p_flag_sticky;
    counter_overflow_flag && !flag_wr_en |=> counter_overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Overflow flag cleared without a software write.");

  property p_idle_hold;
    idle_halt_control && cpu_idle |=> $stable(count_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("Counter moved while halted in idle.");

  property p_idle_run;
    !idle_halt_control && cpu_idle && timebase_select == `ACT_TB_SYS
      |=> count_r != $past(count_r);
  endproperty
  a_idle_run: assert property (p_idle_run)
    else $error("Counter stopped in idle with halt clear.");

  property p_reserved;
    timebase_select[2:1] == 2'b11 |=> $stable(count_r);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Counter moved on a reserved timebase code.");

  property p_shared_value;
    ##1 1'b1 |-> counter_array == count_r;
  endproperty
  a_shared_value: assert property (p_shared_value)
    else $error("Shared counter value differs from the count.");

  c_wrap: cover property (wrap && !rmw_ctrl_active);
  c_rmw_loss: cover property (wrap && rmw_ctrl_active);
  c_event: cover property (timebase_select == `ACT_TB_EXT_EVENT && evt_tick_r);
  c_osc: cover property (timebase_select == `ACT_TB_OSC_DIV8 && tick_osc8);
  c_irq: cover property (irq);

endmodule // act_top

/* File: tb/act_cpu_model.sv */
// Software side of the array counter: issues single byte reads and keeps the returned byte.
`timescale 1ns/1ns
module act_cpu_model
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            go_low,
  input  wire logic            go_high,
  input  act_pkg::act_byte_t   rd_data,
  output logic                 rd_low,
  output logic                 rd_high,
  output act_pkg::act_byte_t   got
);
  import act_pkg::*;
  logic pend_r;
  // ----------------------------------------------------------------------------
  // Read strobes
  // ----------------------------------------------------------------------------
  // A low read wins when both are asked; the high request is dropped, not issued after it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_low  <= 1'b0;
      rd_high <= 1'b0;
      pend_r  <= 1'b0;
      got     <= 8'h00;
    end
    else
    begin
      rd_low  <= go_low;
      rd_high <= go_high & ~go_low;
      pend_r  <= rd_low | rd_high;
      if (pend_r)
        got <= rd_data;
    end
  end
endmodule // act_cpu_model

/* File: tb/array_counter_timebase_bench.sv */
// Self-checking bench for the array counter timebase.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module array_counter_timebase_bench;
  import act_pkg::*;
  logic      clk = 1'b0;
  logic      rst_b = 1'b0;
  logic [2:0] tsel = 3'h6;
  logic      halt = 1'b0;
  logic      idle = 1'b0;
  logic      t0 = 1'b0;
  logic      ev = 1'b1;
  logic      osc = 1'b0;
  logic      fwe = 1'b0;
  logic      fwd = 1'b0;
  logic      rmw = 1'b0;
  logic      oie = 1'b0;
  logic      gie = 1'b0;
  logic      aie = 1'b0;
  logic      go_low = 1'b0;
  logic      go_high = 1'b0;
  logic      rd_low;
  logic      rd_high;
  act_byte_t rd_data;
  act_byte_t got;
  act_word_t cnt;
  logic      flag;
  logic      irq;
  int        checked = 0;
  int        bad_count = 0;
  int        m_cnt = 0;
  int        seed;
  int        n;
  logic [7:0] hi;

  always #2 clk = ~clk;

  act_top dut (.clk(clk), .rst_b(rst_b), .timebase_select(tsel), .idle_halt_control(halt),
    .cpu_idle(idle), .timer0_overflow(t0), .external_event_input(ev), .ext_osc(osc),
    .rd_low(rd_low), .rd_high(rd_high), .flag_wr_en(fwe), .flag_wr_data(fwd),
    .rmw_ctrl_active(rmw), .overflow_interrupt_enable(oie), .global_interrupt_enable(gie),
    .array_interrupt_enable(aie), .rd_data(rd_data), .counter_array(cnt),
    .counter_overflow_flag(flag), .irq(irq));

  act_cpu_model cpu (.clk(clk), .rst_b(rst_b), .go_low(go_low), .go_high(go_high),
    .rd_data(rd_data), .rd_low(rd_low), .rd_high(rd_high), .got(got));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Code 110 freezes the count, so every check is made on a still value.
  task run(input logic [2:0] s, input int k);
    tsel = s;
    tick(k);
    tsel = 3'h6;
    tick(4);
  endtask

  task expect_cnt(input int add);
    m_cnt = (m_cnt + add) % 65536;
    `CHK(cnt, m_cnt[15:0])
  endtask

  task rd(input logic high, input logic [7:0] want);
    go_low = ~high;
    go_high = high;
    tick(1);
    go_low = 1'b0;
    go_high = 1'b0;
    tick(4);
    `CHK(got, want)
  endtask

  // Low read, then the high read two clocks later, as software pairs them.
  task rd_pair(input logic [15:0] want);
    go_low = 1'b1;
    tick(1);
    go_low = 1'b0;
    tick(1);
    go_high = 1'b1;
    tick(1);
    go_high = 1'b0;
    `CHK(got, want[7:0])
    tick(2);
    `CHK(got, want[15:8])
  endtask

  task fin(input string s);
    $display("test %s finished", s);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial
  begin
    seed = $urandom(32'h3FE8AFE5);
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(2);
    `CHK(cnt, 16'h0000)
    run(3'h7, 20);
    expect_cnt(0);
    run(3'h4, 37);
    expect_cnt(37);
    run(3'h1, 48);
    expect_cnt(12);
    run(3'h0, 48);
    expect_cnt(4);
    tsel = 3'h2;
    repeat (5)
    begin
      t0 = 1'b1;
      tick(1);
      t0 = 1'b0;
      tick(1 + $urandom_range(3));
    end
    run(3'h6, 0);
    expect_cnt(5);
    fin("timebase");
    // Each level lasts two to five clocks, so falls are never closer than four.
    tsel = 3'h3;
    tick(4);
    repeat (6)
    begin
      ev = 1'b0;
      tick(2 + $urandom_range(3));
      ev = 1'b1;
      tick(2 + $urandom_range(3));
    end
    run(3'h3, 6);
    expect_cnt(6);
    tsel = 3'h5;
    repeat (32)
    begin
      osc = 1'b1;
      tick(2);
      osc = 1'b0;
      tick(2);
    end
    run(3'h5, 6);
    expect_cnt(4);
    fin("sources");
    halt = 1'b1;
    idle = 1'b1;
    run(3'h4, 20);
    expect_cnt(0);
    halt = 1'b0;
    run(3'h4, 20);
    expect_cnt(20);
    idle = 1'b0;
    fin("idle");
    rd(1'b0, m_cnt[7:0]);
    hi = m_cnt[15:8];
    tsel = 3'h4;
    tick(150);
    rd(1'b1, hi);
    run(3'h4, 145);
    expect_cnt(300);
    rd(1'b0, m_cnt[7:0]);
    rd(1'b1, m_cnt[15:8]);
    fin("reads");
    oie = 1'b1;
    gie = 1'b1;
    aie = 1'b1;
    // Stop two counts short of the wrap so the recovery reads see a high byte of all ones, then zero.
    n = 65536 - m_cnt - 2;
    run(3'h4, n);
    expect_cnt(n);
    rd_pair(m_cnt[15:0]);
    hi = got;
    rmw = 1'b1;
    tick(1 + $urandom_range(3));
    rmw = 1'b0;
    tick(1);
    `CHK(flag, 1'b0)
    run(3'h4, 5);
    expect_cnt(5);
    `CHK(flag, 1'b1)
    `CHK(irq, 1'b1)
    rd_pair(m_cnt[15:0]);
    `CHK({hi, got}, 16'hFF00)
    for (int i = 0; i < 8; i++)
    begin
      {oie, gie, aie} = i[2:0];
      tick(3);
      `CHK(irq, (i == 7))
    end
    `CHK(flag, 1'b1)
    for (int i = 0; i < 3; i++)
    begin
      fwe = 1'b1;
      fwd = i[0];
      tick(1);
      fwe = 1'b0;
      tick(3);
      `CHK(flag, i[0])
      `CHK(irq, i[0])
    end
    fin("overflow");
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(2);
    `CHK(cnt, 16'h0000)
    `CHK(flag, 1'b0)
    `CHK(irq, 1'b0)
    fin("reset");
    conclude();
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // array_counter_timebase_bench
